/* verilog/icp_top.sv */
// Second control registers, clock width registers and pin direction for two channels.
// Assumes the protocol engine supplies events and drive requests, and owns the first control.
`timescale 1ns/1ps

// ****************************************************************
// Configuration and pin block
// ****************************************************************

// Operation
// R1: Wakeup bit keeps address-match wakeup alive in stop mode; cleared halts it.
// R2: Software waits three clocks after setting wakeup before entering stop.
// R3: Software clears wakeup after a match before releasing wait or writing data.
// R4: Match and extension interrupts keep the same timing whatever the wakeup bit.
// R5: Wakeup bit set suppresses the stop-condition interrupt despite its enable.
// R6: Software sets wakeup only while no communication flags are set.
// R7: Clock-line level bit is read-only, zero when disabled or reset.
// R8: Data-line level bit is read-only, zero when disabled or reset.
// R9: Speed bit picks standard mode at 0, fast modes at 1.
// R10: Filter bit switches input noise filter, fast modes only, clock unchanged.
// R11: Prescaler bit picks full or half clock; half needed above 20 MHz.
// R12: Second control resets to zero; writes except wakeup only while disabled.
// R13: Low width sets clock low time, upper six bits hold time; disabled writes.
// R14: High width sets clock high time, resets to all ones, disabled writes.
// R15: Direction bits: 0 drives pin, 1 input; upper six read one.
// R16: While disabled, both bus pins drive a fixed low.
// R17: Software clears both direction bits and sets both output latches for the bus.
// R18: Low and high periods count operation-clock ticks equal to the width values.
module icp_top (
  input wire logic clk, // Peripheral clock, 250 MHz.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic [19:0] reg_addr, // Register byte address.
  input wire logic reg_wr, // Write strobe.
  input wire logic [7:0] reg_wdata, // Write data.
  input wire logic reg_rd, // Read strobe.
  output logic [7:0] reg_rdata, // Read data, valid the cycle after the strobe.
  input wire logic [1:0] ctrl_enable, // Controller enable per channel.
  input icp_pkg::icp_eng_t [1:0] eng, // Engine events per channel.
  input wire logic [1:0] eng_sda_low, // Engine wants data line low.
  input wire logic [1:0] port_latch, // Port output latches of the two pins.
  input wire logic [1:0] pin_in, // Pin levels: 0 clock, 1 data.
  output logic [1:0] pin_out, // Pin output value, always low (open drain).
  output logic [1:0] pin_oe, // Pin drive enable, high pulls low.
  output logic [1:0] irq, // Channel interrupt pulse.
  output logic [1:0] wake_req, // Stop-mode wakeup request pulse.
  output logic [1:0] fast_mode, // Fast or fast-plus mode selected.
  output logic [1:0] opclk_en, // Operation clock enable per channel.
  output logic [1:0] opclk_over_limit, // Full clock selected though above the limit.
  output logic [1:0] bus_clk_level, // Filtered clock level.
  output logic [1:0] bus_data_level, // Filtered data level.
  output logic [1:0] hold_done // Data hold time elapsed pulse.
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    icp_pkg::icp_ctl2_t [1:0] ctl2;
    logic [1:0][7:0] low_w;
    logic [1:0][7:0] high_w;
    logic [1:0] pdir;
    logic [7:0] rdata;
    logic [1:0] irq;
    logic [1:0] wake_req;
    logic [1:0] pin_oe;
  } icp_top_st_t;

  localparam icp_top_st_t ST_RESET = '{
    ctl2: {2{icp_pkg::CTL2_RESET}},
    low_w: {2{icp_pkg::WIDTH_RESET}},
    high_w: {2{icp_pkg::WIDTH_RESET}},
    pdir: icp_pkg::PORT_DIR_RESET,
    rdata: 8'h00,
    irq: 2'b00,
    wake_req: 2'b00,
    pin_oe: 2'b00
  };

  icp_top_st_t st;
  icp_top_st_t next_st;
  icp_pkg::icp_cfg_t [1:0] cfg;
  icp_pkg::icp_line_t [1:0] line;
  icp_pkg::icp_ctl2_t wr_ctl2;
  logic own;
  logic en_any;

  // Address compare shared by the write and read paths.
  function automatic logic icp_hit(input logic [19:0] addr, input logic [19:0] target);
    return addr == target;
  endfunction : icp_hit

  // ****************************************************************
  // Channels
  // ****************************************************************
  // Each channel sees the shared pins; only the owning channel drives them.
  for (genvar c = 0; c < icp_pkg::NUM_CH; c++) begin : g_ch
    assign cfg[c].enable = ctrl_enable[c];
    assign cfg[c].half = st.ctl2[c].half;
    assign cfg[c].fast = st.ctl2[c].speed; // see R9
    assign cfg[c].filt = st.ctl2[c].filt;
    assign cfg[c].low_width = st.low_w[c];
    assign cfg[c].high_width = st.high_w[c];
    icp_chan u_chan (
      .clk(clk),
      .rst_n(rst_n),
      .cfg(cfg[c]),
      .run(eng[c].run),
      .scl_in(pin_in[0]),
      .sda_in(pin_in[1]),
      .line(line[c])
    );
  end

  // Channel 1 owns the pins only when it alone is enabled, channel 0 otherwise.
  assign own = !ctrl_enable[0] && ctrl_enable[1];
  assign en_any = |ctrl_enable;
  assign wr_ctl2 = icp_pkg::icp_ctl2_t'(reg_wdata);

  // ****************************************************************
  // Register file, events and pin drive
  // ****************************************************************
  always_comb begin
    logic [7:0] rd;
    logic evt;
    icp_pkg::icp_ctl2_t view;
    rd = 8'h00;
    evt = 1'b0;
    view = '0;
    next_st = st;
    for (int c = 0; c < icp_pkg::NUM_CH; c++) begin
      // The wakeup bit may change at any time; the rest is locked while running.
      if (reg_wr && icp_hit(reg_addr, icp_pkg::CTL2_ADDR[c])) begin
        next_st.ctl2[c].wake = wr_ctl2.wake; // see R1, R12
        if (!ctrl_enable[c]) begin
          next_st.ctl2[c].speed = wr_ctl2.speed; // see R12
          next_st.ctl2[c].filt = wr_ctl2.filt;
          next_st.ctl2[c].half = wr_ctl2.half;
        end
      end
      if (reg_wr && !ctrl_enable[c] && icp_hit(reg_addr, icp_pkg::LOW_W_ADDR[c])) begin
        next_st.low_w[c] = reg_wdata; // see R13
      end
      if (reg_wr && !ctrl_enable[c] && icp_hit(reg_addr, icp_pkg::HIGH_W_ADDR[c])) begin
        next_st.high_w[c] = reg_wdata; // see R14
      end
      // Level bits are not stored; reads show the sampled lines.
      view = st.ctl2[c];
      view.clk_lvl = line[c].scl_level; // see R7
      view.data_lvl = line[c].sda_level; // see R8
      if (icp_hit(reg_addr, icp_pkg::CTL2_ADDR[c])) begin
        rd = view;
      end
      if (icp_hit(reg_addr, icp_pkg::LOW_W_ADDR[c])) begin
        rd = st.low_w[c];
      end
      if (icp_hit(reg_addr, icp_pkg::HIGH_W_ADDR[c])) begin
        rd = st.high_w[c];
      end
      // Match interrupts do not look at wakeup, so their timing never moves.
      evt = eng[c].addr_event || eng[c].ext_event;
      next_st.irq[c] = ctrl_enable[c] && (evt // see R4
        || (eng[c].stop_event && eng[c].stop_irq_en && !st.ctl2[c].wake)); // see R5
      next_st.wake_req[c] = ctrl_enable[c] && st.ctl2[c].wake && eng[c].stop_mode && evt; // see R1
    end
    if (reg_wr && icp_hit(reg_addr, icp_pkg::PORT6_ADDR)) begin
      next_st.pdir = reg_wdata[1:0];
    end
    if (icp_hit(reg_addr, icp_pkg::PORT6_ADDR)) begin
      rd = {icp_pkg::PORT_UPPER_ONES, st.pdir}; // see R15
    end
    if (reg_rd) begin
      next_st.rdata = rd;
    end
    // Output buffer on only with direction 0; with no controller enabled, both pins are pulled low.
    next_st.pin_oe[0] = !st.pdir[0] // see R15
      && (!en_any || !port_latch[0] || line[own].scl_low); // see R16
    next_st.pin_oe[1] = !st.pdir[1]
      && (!en_any || !port_latch[1] || eng_sda_low[own]); // see R16
  end

  // State register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Open drain: the driven value is always low, the enable does the work.
  assign pin_out = 2'b00;
  assign pin_oe = st.pin_oe;
  assign reg_rdata = st.rdata;
  assign irq = st.irq;
  assign wake_req = st.wake_req;
  always_comb begin
    for (int c = 0; c < icp_pkg::NUM_CH; c++) begin
      fast_mode[c] = st.ctl2[c].speed; // see R9
      opclk_en[c] = line[c].opclk_en;
      // Flags a prescaler left at full rate on this clock; software must fix it.
      opclk_over_limit[c] = icp_pkg::HALF_NEEDED && !st.ctl2[c].half; // see R11
      bus_clk_level[c] = line[c].scl_level;
      bus_data_level[c] = line[c].sda_level;
      hold_done[c] = line[c].hold_done;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_ctl2_locked;
    @(posedge clk) disable iff (!rst_n)
      reg_wr && icp_hit(reg_addr, icp_pkg::CTL2_ADDR[0]) && ctrl_enable[0]
      |=> $stable(st.ctl2[0].speed) && $stable(st.ctl2[0].half) && $stable(st.ctl2[0].filt);
  endproperty
  a_ctl2_locked: assert property (p_ctl2_locked) else $error("control written while on"); // see R12
  property p_wake_write;
    @(posedge clk) disable iff (!rst_n)
      reg_wr && icp_hit(reg_addr, icp_pkg::CTL2_ADDR[0])
      |=> st.ctl2[0].wake == $past(reg_wdata[7]);
  endproperty
  a_wake_write: assert property (p_wake_write) else $error("wakeup bit not written"); // see R1
  property p_low_locked;
    @(posedge clk) disable iff (!rst_n)
      ctrl_enable[1] && icp_hit(reg_addr, icp_pkg::LOW_W_ADDR[1]) |=> $stable(st.low_w[1]);
  endproperty
  a_low_locked: assert property (p_low_locked) else $error("low width changed while on"); // see R13
  property p_high_write;
    @(posedge clk) disable iff (!rst_n)
      reg_wr && !ctrl_enable[0] && icp_hit(reg_addr, icp_pkg::HIGH_W_ADDR[0])
      |=> st.high_w[0] == $past(reg_wdata);
  endproperty
  a_high_write: assert property (p_high_write) else $error("high width not written"); // see R14
  property p_stop_masked;
    @(posedge clk) disable iff (!rst_n)
      st.ctl2[0].wake && !eng[0].addr_event && !eng[0].ext_event |=> !irq[0];
  endproperty
  a_stop_masked: assert property (p_stop_masked) else $error("stop irq with wakeup"); // see R5
  property p_match_irq;
    @(posedge clk) disable iff (!rst_n) ctrl_enable[1] && eng[1].addr_event |=> irq[1];
  endproperty
  a_match_irq: assert property (p_match_irq) else $error("match irq missing"); // see R4
  property p_port_read;
    @(posedge clk) disable iff (!rst_n)
      reg_rd && icp_hit(reg_addr, icp_pkg::PORT6_ADDR)
      |=> reg_rdata == {icp_pkg::PORT_UPPER_ONES, $past(st.pdir)};
  endproperty
  a_port_read: assert property (p_port_read) else $error("port read wrong"); // see R15
  property p_off_low;
    @(posedge clk) disable iff (!rst_n) !en_any && !st.pdir[1] |=> pin_oe[1];
  endproperty
  a_off_low: assert property (p_off_low) else $error("pin not low when off"); // see R16
  property p_input_mode;
    @(posedge clk) disable iff (!rst_n) st.pdir[0] && $stable(st.pdir) |-> !pin_oe[0];
  endproperty
  a_input_mode: assert property (p_input_mode) else $error("pin driven in input mode"); // see R15
  property p_wake_req;
    @(posedge clk) disable iff (!rst_n)
      wake_req[0] |-> $past(st.ctl2[0].wake) && $past(eng[0].stop_mode);
  endproperty
  a_wake_req: assert property (p_wake_req) else $error("wakeup without bit"); // see R1
  c_wake: cover property (@(posedge clk) disable iff (!rst_n) wake_req[0]);
  c_stop_masked: cover property (@(posedge clk) disable iff (!rst_n)
    st.ctl2[0].wake && eng[0].stop_event && eng[0].stop_irq_en);
  c_bus_mode: cover property (@(posedge clk) disable iff (!rst_n)
    ctrl_enable[0] && st.pdir == 2'b00);

endmodule : icp_top

/* verilog/icp_pkg.sv */
// Shared constants and types for the bus-pin configuration block.
// Assumes a byte-wide register port and two controller channels sharing one pin pair.
package icp_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int NUM_CH = 2;
  localparam logic [1:0][19:0] CTL2_ADDR = {20'hF_0239, 20'hF_0231};
  localparam logic [1:0][19:0] LOW_W_ADDR = {20'hF_023A, 20'hF_0232};
  localparam logic [1:0][19:0] HIGH_W_ADDR = {20'hF_023B, 20'hF_0233};
  localparam logic [19:0] PORT6_ADDR = 20'hF_FF26;
  localparam logic [7:0] CTL2_RESET = 8'h00;
  localparam logic [7:0] WIDTH_RESET = 8'hFF;
  localparam logic [1:0] PORT_DIR_RESET = 2'h3;
  localparam logic [5:0] PORT_UPPER_ONES = 6'h3F;

  // ****************************************************************
  // Timing and filtering
  // ****************************************************************
  localparam int HOLD_LSB = 2;
  localparam int FILT_TAPS = 3;
  localparam int CLK_MHZ = 250;
  localparam int OPCLK_MAX_MHZ = 20;
  localparam logic HALF_NEEDED = (CLK_MHZ > OPCLK_MAX_MHZ);

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic wake;
    logic rsv6;
    logic clk_lvl;
    logic data_lvl;
    logic speed;
    logic filt;
    logic rsv1;
    logic half;
  } icp_ctl2_t;

  typedef struct packed {
    logic enable;
    logic half;
    logic fast;
    logic filt;
    logic [7:0] low_width;
    logic [7:0] high_width;
  } icp_cfg_t;

  typedef struct packed {
    logic run;
    logic stop_mode;
    logic stop_event;
    logic stop_irq_en;
    logic addr_event;
    logic ext_event;
  } icp_eng_t;

  typedef struct packed {
    logic scl_level;
    logic sda_level;
    logic scl_low;
    logic hold_done;
    logic opclk_en;
  } icp_line_t;

  typedef enum logic [1:0] {
    ICP_IDLE = 2'b00,
    ICP_LOW = 2'b01,
    ICP_HIGH = 2'b10
  } icp_phase_t;

endpackage : icp_pkg

/* verilog/icp_chan.sv */
// One channel's operation-clock divider, input filter and clock width timer.
// Assumes pin levels arrive synchronous to clk and configuration is steady while enabled.
`timescale 1ns/1ps
module icp_chan #(
  parameter int FILT_TAPS = icp_pkg::FILT_TAPS
) (
  input wire logic clk, // Peripheral clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input icp_pkg::icp_cfg_t cfg, // Channel configuration.
  input wire logic run, // Engine asks for clock generation.
  input wire logic scl_in, // Clock pin level.
  input wire logic sda_in, // Data pin level.
  output icp_pkg::icp_line_t line // Levels, timing and tick.
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic div;
    icp_pkg::icp_phase_t phase;
    logic [7:0] cnt;
    logic [5:0] hold;
    logic hold_done;
    logic [FILT_TAPS-1:0] scl_hist;
    logic [FILT_TAPS-1:0] sda_hist;
    logic scl_level;
    logic sda_level;
  } icp_chan_st_t;

  icp_chan_st_t st;
  icp_chan_st_t next_st;
  logic tick;
  logic filt_on;
  logic go_low;

  // Filtered level: follows the pin only once all taps agree.
  function automatic logic icp_filt(input logic [FILT_TAPS-1:0] hist, input logic prev,
                                    input logic on, input logic raw);
    if (!on) begin
      return raw;
    end
    if (&hist) begin
      return 1'b1;
    end
    if (~|hist) begin
      return 1'b0;
    end
    return prev;
  endfunction : icp_filt

  // True when cnt marks the last tick of a period of width ticks; zero acts as one.
  function automatic logic icp_done(input logic [7:0] cnt, input logic [7:0] width);
    return ({1'b0, cnt} + 9'h001) >= {1'b0, width};
  endfunction : icp_done

  // Operation clock is every cycle or every other cycle.
  assign tick = !cfg.half || st.div; // see R11
  // The filter only acts in the fast modes, and never touches the width counts.
  assign filt_on = cfg.filt && cfg.fast; // see R10

  // Next-state logic.
  always_comb begin
    next_st = st;
    go_low = 1'b0;
    next_st.hold_done = 1'b0;
    next_st.div = cfg.half ? ~st.div : 1'b0;
    next_st.scl_hist = {st.scl_hist[FILT_TAPS-2:0], scl_in};
    next_st.sda_hist = {st.sda_hist[FILT_TAPS-2:0], sda_in};
    next_st.scl_level = icp_filt(next_st.scl_hist, st.scl_level, filt_on, scl_in);
    next_st.sda_level = icp_filt(next_st.sda_hist, st.sda_level, filt_on, sda_in);
    unique case (st.phase)
      icp_pkg::ICP_IDLE: begin
        go_low = run;
      end
      icp_pkg::ICP_LOW: begin
        if (tick) begin
          if (st.hold != 6'h00) begin
            next_st.hold = st.hold - 6'h01;
          end
          next_st.hold_done = (st.hold == 6'h01);
          if (icp_done(st.cnt, cfg.low_width)) begin // see R18
            next_st.phase = icp_pkg::ICP_HIGH;
            next_st.cnt = 8'h00;
          end else begin
            next_st.cnt = st.cnt + 8'h01;
          end
        end
      end
      icp_pkg::ICP_HIGH: begin
        // High time starts once the line is really high, so a stretching peer is honoured.
        if (tick && st.scl_level) begin
          if (icp_done(st.cnt, cfg.high_width)) begin // see R18
            next_st.phase = icp_pkg::ICP_IDLE;
            go_low = run;
          end else begin
            next_st.cnt = st.cnt + 8'h01;
          end
        end
      end
      default: begin
        next_st.phase = icp_pkg::ICP_IDLE;
      end
    endcase
    if (go_low) begin
      next_st.phase = icp_pkg::ICP_LOW;
      next_st.cnt = 8'h00;
      next_st.hold = cfg.low_width[7:icp_pkg::HOLD_LSB]; // see R13
      next_st.hold_done = (cfg.low_width[7:icp_pkg::HOLD_LSB] == 6'h00);
    end
    // Disabled: levels read 0 and the timer rests.
    if (!cfg.enable) begin
      next_st = '0; // see R7, R8
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign line.scl_level = st.scl_level;
  assign line.sda_level = st.sda_level;
  assign line.scl_low = (st.phase == icp_pkg::ICP_LOW);
  assign line.hold_done = st.hold_done;
  assign line.opclk_en = cfg.enable && tick;

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_levels_off;
    @(posedge clk) disable iff (!rst_n) !cfg.enable |=> !st.scl_level && !st.sda_level;
  endproperty
  a_levels_off: assert property (p_levels_off) else $error("levels not zero when off"); // see R7
  property p_half_rate;
    @(posedge clk) disable iff (!rst_n) cfg.half && $stable(cfg.half) && tick |=> !tick;
  endproperty
  a_half_rate: assert property (p_half_rate) else $error("half rate tick twice"); // see R11
  property p_unfiltered;
    @(posedge clk) disable iff (!rst_n)
      cfg.enable && !filt_on ##1 cfg.enable |-> st.scl_level == $past(scl_in);
  endproperty
  a_unfiltered: assert property (p_unfiltered) else $error("unfiltered level lags"); // see R10
  property p_low_holds;
    @(posedge clk) disable iff (!rst_n)
      cfg.enable && st.phase == icp_pkg::ICP_LOW && !icp_done(st.cnt, cfg.low_width)
      |=> st.phase == icp_pkg::ICP_LOW || !cfg.enable;
  endproperty
  a_low_holds: assert property (p_low_holds) else $error("low period cut short"); // see R18
  c_high_phase: cover property (@(posedge clk) st.phase == icp_pkg::ICP_HIGH);

endmodule : icp_chan

/* verification/icp_peer.sv */
// Bus peer model: pull-ups on both lines and one more party that may hold either line low.
// Assumes the block's drive enable means pulling the line low, as on an open-drain pin.
`timescale 1ns/1ps
module icp_peer (
  input wire logic [1:0] dut_oe, // Block pulls the line low.
  input wire logic [1:0] peer_low, // Peer holds the line low.
  output logic [1:0] line // Wired level, bit 0 clock, bit 1 data.
);
  // Any party pulling wins; otherwise the pull-up returns the line high, never a stale value.
  assign line = ~(dut_oe | peer_low);
endmodule : icp_peer

/* verification/icp_top_test.sv */
// Self-checking bench for the configuration and pin block, channel 0 in depth.
// Assumes the peer model closes the pin loop and reads answer one cycle after the strobe.
`timescale 1ns/1ps
`define CHK(a, b, m) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("CHECK FAILED %0t %s", $time, m); end end
module icp_top_test;
  logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, rd_seen = 0;
  logic [19:0] reg_addr = '0;
  logic [7:0] reg_wdata = '0, w, e, rv;
  logic [1:0] ctrl_enable = '0, eng_sda_low = '0, port_latch = 2'b11, pin_in, peer_low = '0;
  logic [1:0] pin_out, pin_oe, irq, wake_req, fast_mode, opclk_en, over, clv, dlv, hold_done;
  icp_pkg::icp_eng_t [1:0] eng = '0;
  logic [7:0] rq[$];
  int bad_count = 0, num_checks = 0, seed = 32'h0d6185cb;
  icp_top DUT (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(w), .ctrl_enable(ctrl_enable),
    .eng(eng), .eng_sda_low(eng_sda_low), .port_latch(port_latch), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq), .wake_req(wake_req), .fast_mode(fast_mode),
    .opclk_en(opclk_en), .opclk_over_limit(over), .bus_clk_level(clv), .bus_data_level(dlv),
    .hold_done(hold_done));
  icp_peer peer (.dut_oe(pin_oe), .peer_low(peer_low), .line(pin_in));
  // A 4 ns period gives the 250 MHz peripheral clock.
  always #2 clk = ~clk;
  // Reads are noted when issued and compared when the answer lands, oldest first.
  always @(posedge clk) rd_seen <= reg_rd;
  always @(negedge clk) if (rd_seen) begin
    e = rq.pop_front();
    `CHK(w, e, "read data")
  end
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [19:0] a, input logic [7:0] x);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    rq.push_back(x);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask : rd
  // One event cycle on channel 0: 0 match, 1 extension, 2 stop condition.
  task automatic pulse(input int k, input logic ei, input logic ew);
    @(posedge clk);
    eng[0].addr_event <= (k == 0);
    eng[0].ext_event <= (k == 1);
    eng[0].stop_event <= (k == 2);
    @(posedge clk);
    eng[0].addr_event <= 1'b0;
    eng[0].ext_event <= 1'b0;
    eng[0].stop_event <= 1'b0;
    @(negedge clk);
    `CHK(irq[0], ei, "interrupt")
    if (k < 2) `CHK(wake_req[0], ew, "wakeup request")
  endtask : pulse
  task stop_test;
    if (bad_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  // Watchdog: the sequence needs well under a thousand cycles.
  initial begin
    #20000;
    bad_count++;
    stop_test;
  end
  // Main sequence.
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd(icp_pkg::CTL2_ADDR[0], 8'h00);
    rd(icp_pkg::CTL2_ADDR[1], 8'h00);
    rd(icp_pkg::LOW_W_ADDR[0], 8'hFF);
    rd(icp_pkg::HIGH_W_ADDR[1], 8'hFF);
    rd(icp_pkg::PORT6_ADDR, 8'hFF);
    rd(20'hF_0234, 8'h00);
    rv = 8'($random(seed));
    wr(icp_pkg::LOW_W_ADDR[0], rv);
    rd(icp_pkg::LOW_W_ADDR[0], rv);
    // Disabled: every writable bit lands, level bits stay zero.
    wr(icp_pkg::CTL2_ADDR[0], 8'hFF);
    rd(icp_pkg::CTL2_ADDR[0], 8'h8D);
    @(negedge clk);
    `CHK(fast_mode[0], 1'b1, "speed mode")
    `CHK(over[0], 1'b0, "prescaler limit")
    // Enabled: only the wakeup bit moves, levels follow the idle bus.
    ctrl_enable <= 2'b01;
    repeat (8) @(posedge clk);
    wr(icp_pkg::CTL2_ADDR[0], 8'h00);
    rd(icp_pkg::CTL2_ADDR[0], 8'h3D);
    wr(icp_pkg::HIGH_W_ADDR[0], 8'h12);
    rd(icp_pkg::HIGH_W_ADDR[0], 8'hFF);
    peer_low <= 2'b10;
    repeat (8) @(posedge clk);
    rd(icp_pkg::CTL2_ADDR[0], 8'h2D);
    @(negedge clk);
    `CHK(dlv[0], 1'b0, "data level")
    `CHK(clv[0], 1'b1, "clock level")
    `CHK(pin_out, 2'b00, "open drain value")
    peer_low <= 2'b00;
    // Events with wakeup off then on, in stop mode with the stop interrupt enabled.
    eng[0].stop_irq_en <= 1'b1;
    for (int wk = 0; wk < 2; wk++) begin
      // Wakeup is only set while no transfer is under way.
      wr(icp_pkg::CTL2_ADDR[0], {wk[0], 7'h00});
      repeat (3) @(posedge clk);
      eng[0].stop_mode <= 1'b1;
      pulse(0, 1'b1, wk[0]);
      pulse(1, 1'b1, wk[0]);
      pulse(2, !wk[0], 1'b0);
    end
    wr(icp_pkg::CTL2_ADDR[0], 8'h00);
    // Pins: released while enabled, latched high and idle; disabled forces a low.
    wr(icp_pkg::PORT6_ADDR, 8'h00);
    rd(icp_pkg::PORT6_ADDR, 8'hFC);
    repeat (3) @(posedge clk);
    @(negedge clk);
    `CHK(pin_oe, 2'b00, "bus idle released")
    ctrl_enable <= 2'b00;
    repeat (3) @(posedge clk);
    @(negedge clk);
    `CHK(pin_oe, 2'b11, "disabled pins low")
    wr(icp_pkg::PORT6_ADDR, 8'hFF);
    repeat (3) @(posedge clk);
    @(negedge clk);
    `CHK(pin_oe, 2'b00, "input mode")
    stop_test;
  end
endmodule : icp_top_test
